//--- verilog/nvac_consts.svh
// constants for the nonvolatile access controller
`ifndef NVAC_CONSTS_SVH
`define NVAC_CONSTS_SVH
`define NVAC_OFS_ADDR_LOW 12'h000
`define NVAC_OFS_ADDR_HIGH 12'h004
`define NVAC_OFS_DATA_LOW 12'h008
`define NVAC_OFS_DATA_HIGH 12'h00C
`define NVAC_OFS_CONTROL 12'h010
`define NVAC_OFS_UNLOCK 12'h014
`define NVAC_OFS_IRQ_FLAGS 12'h018
`define NVAC_OFS_IRQ_MASK 12'h01C
`define NVAC_OFS_PROTECT 12'h020
`define NVAC_BIT_READ_GO 0
`define NVAC_BIT_STORE_GO 1
`define NVAC_BIT_PERMIT 2
`define NVAC_BIT_ABORT 3
`define NVAC_BIT_SPACE 7
`define NVAC_BIT_DONE 0
`define NVAC_BIT_REFUSED 1
`define NVAC_KEY_FIRST 8'h55
`define NVAC_KEY_SECOND 8'hAA
`define NVAC_WRITE_TIME_US 4
`define NVAC_CLK_MHZ 10
`define NVAC_WRITE_CYCLES (`NVAC_WRITE_TIME_US * `NVAC_CLK_MHZ)
`define NVAC_READ_CYCLES 2
`define NVAC_EE_AW 8
`define NVAC_PM_AW 15
`define NVAC_PM_DW 14
`define NVAC_EE_DEPTH 256
`define NVAC_PM_DEPTH 32768
`endif

//--- verilog/nvac_pkg.sv
// types for the nonvolatile access controller
package nvac_pkg;
  typedef enum logic [1:0] {
    NVAC_IDLE = 2'b00,
    NVAC_READ = 2'b01,
    NVAC_ERASE = 2'b11,
    NVAC_STORE = 2'b10
  } nvac_state_t;
  typedef struct packed {
    logic space;
    logic [14:0] addr;
    logic [13:0] data;
  } nvac_req_t;
endpackage

//--- verilog/nvac_mem.sv
// one memory array with registered read data
`timescale 1ns/1ps
module nvac_mem #(
  parameter int AW = 8,
  parameter int DW = 8,
  parameter int DEPTH = 256
) (
  // clock
  input wire logic mclk,
  // access
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] cells [DEPTH];
  // no reset on the array: contents survive device reset as in real storage
  always_ff @(posedge mclk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
  end
  always_ff @(posedge mclk) begin
    if (re) begin
      rdata <= cells[addr];
    end
  end
endmodule

//--- verilog/nvac_key_check.sv
// two-step unlock key tracker
`timescale 1ns/1ps
`include "nvac_consts.svh"
module nvac_key_check import nvac_pkg::*; #(
  parameter logic [7:0] KEY_FIRST = `NVAC_KEY_FIRST,
  parameter logic [7:0] KEY_SECOND = `NVAC_KEY_SECOND
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // bus events
  input wire logic keyWrite,
  input wire logic [7:0] keyData,
  input wire logic otherWrite,
  input wire logic consume,
  output logic unlocked
);
  logic firstSeen_reg;
  // any other bus write breaks the sequence, so the keys must come just before
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      firstSeen_reg <= 1'b0;
      unlocked <= 1'b0;
    end else if (keyWrite) begin
      firstSeen_reg <= (keyData == KEY_FIRST);
      unlocked <= firstSeen_reg && (keyData == KEY_SECOND);
    end else if (otherWrite || consume) begin
      firstSeen_reg <= 1'b0;
      unlocked <= 1'b0;
    end
  end
endmodule

//--- verilog/nvac_top.sv
// nonvolatile access controller with APB register slave
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`include "nvac_consts.svh"
module nvac_top import nvac_pkg::*; #(
  parameter logic [7:0] KEY_FIRST = `NVAC_KEY_FIRST,
  parameter logic [7:0] KEY_SECOND = `NVAC_KEY_SECOND
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] addrLow_reg, addrHigh_reg, dataLow_reg, dataHigh_reg;
  logic spaceSelect_reg, storePermit_reg, readGo_reg, storeGo_reg;
  logic abortFlag_reg, writeBusy_reg;
  logic [1:0] irqFlags_reg, irqMask_reg;
  logic protect_reg;
  nvac_state_t state_reg;
  logic [7:0] timer_reg;
  nvac_req_t req;
  logic wrAcc, rdAcc, unlocked, startStore, startRead, opDone;
  logic refused, storeOk, eeWe, pmWe, eeRe, pmRe;
  logic [7:0] eeRdata;
  logic [13:0] pmRdata;
  logic [31:0] rdMux;
  logic newSpace;

  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  assign req.space = spaceSelect_reg;
  assign req.addr = spaceSelect_reg ? {addrHigh_reg[6:0], addrLow_reg}
                                    : {7'h00, addrLow_reg};
  assign req.data = spaceSelect_reg ? {dataHigh_reg[5:0], dataLow_reg}
                                    : {6'h00, dataLow_reg};

  // ------------------------------------------------------------
  // unlock sequence
  // ------------------------------------------------------------
  nvac_key_check #(
    .KEY_FIRST(KEY_FIRST),
    .KEY_SECOND(KEY_SECOND)
  ) u_key (
    .mclk(mclk),
    .reset(reset),
    .keyWrite(wrAcc && paddr == `NVAC_OFS_UNLOCK),
    .keyData(pwdata[7:0]),
    .otherWrite(wrAcc && paddr != `NVAC_OFS_UNLOCK &&
                paddr != `NVAC_OFS_CONTROL),
    .consume(wrAcc && paddr == `NVAC_OFS_CONTROL),
    .unlocked(unlocked)
  );

  // a start is taken only while idle; set-only bits ignore writes of zero
  assign startStore = wrAcc && paddr == `NVAC_OFS_CONTROL &&
                      pwdata[`NVAC_BIT_STORE_GO] && !storeGo_reg &&
                      !readGo_reg;
  assign startRead = wrAcc && paddr == `NVAC_OFS_CONTROL &&
                     pwdata[`NVAC_BIT_READ_GO] && !readGo_reg &&
                     !storeGo_reg && !pwdata[`NVAC_BIT_STORE_GO];
  // space and permit as written in the starting control write govern it,
  // so a single write may pick the space and start the store together
  assign newSpace = pwdata[`NVAC_BIT_SPACE];
  assign storeOk = unlocked && (pwdata[`NVAC_BIT_PERMIT]) &&
                   !(newSpace && protect_reg);
  assign refused = startStore && !storeOk;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      spaceSelect_reg <= 1'b0;
      storePermit_reg <= 1'b0;
    end else if (wrAcc && paddr == `NVAC_OFS_CONTROL) begin
      spaceSelect_reg <= pwdata[`NVAC_BIT_SPACE];
      storePermit_reg <= pwdata[`NVAC_BIT_PERMIT];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      readGo_reg <= 1'b0;
      storeGo_reg <= 1'b0;
    end else begin
      if (startRead) begin
        readGo_reg <= 1'b1;
      end else if (opDone && state_reg == NVAC_READ) begin
        readGo_reg <= 1'b0;
      end
      if (startStore && storeOk) begin
        storeGo_reg <= 1'b1;
      end else if (opDone && state_reg == NVAC_STORE) begin
        storeGo_reg <= 1'b0;
      end
    end
  end

  // busy marker lives in a non-reset flop so the abort can be seen after
  always_ff @(posedge mclk) begin
    writeBusy_reg <= storeGo_reg && !(opDone && state_reg == NVAC_STORE);
  end

  // abort flag is caught at the first clock edge after reset rises, from the surviving busy marker
  logic inReset_reg;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      inReset_reg <= 1'b1;
    end else begin
      inReset_reg <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (inReset_reg && writeBusy_reg) begin
      abortFlag_reg <= 1'b1;
    end else if (inReset_reg && !writeBusy_reg && abortFlag_reg !== 1'b1) begin
      abortFlag_reg <= 1'b0;
    end else if (wrAcc && paddr == `NVAC_OFS_CONTROL &&
                 !pwdata[`NVAC_BIT_ABORT]) begin
      abortFlag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // sequencer and timer
  // ------------------------------------------------------------
  assign opDone = (state_reg != NVAC_IDLE) && (timer_reg == 8'h00);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= NVAC_IDLE;
      timer_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        NVAC_IDLE: begin
          if (startRead) begin
            state_reg <= NVAC_READ;
            timer_reg <= 8'(`NVAC_READ_CYCLES - 1);
          end else if (startStore && storeOk) begin
            state_reg <= newSpace ? NVAC_STORE : NVAC_ERASE;
            timer_reg <= 8'(`NVAC_WRITE_CYCLES - 1);
          end
        end
        NVAC_READ, NVAC_STORE: begin
          if (timer_reg == 8'h00) begin
            state_reg <= NVAC_IDLE;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        NVAC_ERASE: begin
          if (timer_reg == 8'h00) begin
            state_reg <= NVAC_STORE;
            timer_reg <= 8'(`NVAC_WRITE_CYCLES - 1);
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // memories
  // ------------------------------------------------------------
  // data space 8-bit address, program space 15-bit word address
  assign eeWe = opDone && state_reg == NVAC_STORE && !req.space &&
                storePermit_reg;
  assign pmWe = opDone && state_reg == NVAC_STORE && req.space &&
                storePermit_reg && !protect_reg;
  assign eeRe = opDone && state_reg == NVAC_READ && !req.space;
  assign pmRe = opDone && state_reg == NVAC_READ && req.space;

  nvac_mem #(
    .AW(`NVAC_EE_AW),
    .DW(8),
    .DEPTH(`NVAC_EE_DEPTH)
  ) u_ee (
    .mclk(mclk),
    .we(eeWe),
    .re(eeRe),
    .addr(req.addr[7:0]),
    .wdata(req.data[7:0]),
    .rdata(eeRdata)
  );
  nvac_mem #(
    .AW(`NVAC_PM_AW),
    .DW(`NVAC_PM_DW),
    .DEPTH(`NVAC_PM_DEPTH)
  ) u_pm (
    .mclk(mclk),
    .we(pmWe),
    .re(pmRe),
    .addr(req.addr),
    .wdata(req.data),
    .rdata(pmRdata)
  );

  // read result lands one cycle after the read strobe
  logic readLand_reg, readSpace_reg;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      readLand_reg <= 1'b0;
      readSpace_reg <= 1'b0;
    end else begin
      readLand_reg <= eeRe || pmRe;
      readSpace_reg <= req.space;
    end
  end

  // ------------------------------------------------------------
  // address and data registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addrLow_reg <= 8'h00;
      addrHigh_reg <= 8'h00;
    end else if (wrAcc && paddr == `NVAC_OFS_ADDR_LOW) begin
      addrLow_reg <= pwdata[7:0];
    end else if (wrAcc && paddr == `NVAC_OFS_ADDR_HIGH) begin
      addrHigh_reg <= {1'b0, pwdata[6:0]};
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dataLow_reg <= 8'h00;
      dataHigh_reg <= 8'h00;
    end else if (readLand_reg) begin
      dataLow_reg <= readSpace_reg ? pmRdata[7:0] : eeRdata;
      if (readSpace_reg) begin
        dataHigh_reg <= {2'b00, pmRdata[13:8]};
      end
    end else if (wrAcc && paddr == `NVAC_OFS_DATA_LOW) begin
      dataLow_reg <= pwdata[7:0];
    end else if (wrAcc && paddr == `NVAC_OFS_DATA_HIGH) begin
      dataHigh_reg <= {2'b00, pwdata[5:0]};
    end
  end

  // ------------------------------------------------------------
  // interrupts and protection
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqFlags_reg <= 2'b00;
      irqMask_reg <= 2'b00;
      protect_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      // set wins over a write-one clear
      irqFlags_reg[`NVAC_BIT_DONE] <= (opDone && state_reg == NVAC_STORE) ||
        (irqFlags_reg[`NVAC_BIT_DONE] && !(wrAcc &&
         paddr == `NVAC_OFS_IRQ_FLAGS && pwdata[`NVAC_BIT_DONE]));
      irqFlags_reg[`NVAC_BIT_REFUSED] <= refused ||
        (irqFlags_reg[`NVAC_BIT_REFUSED] && !(wrAcc &&
         paddr == `NVAC_OFS_IRQ_FLAGS && pwdata[`NVAC_BIT_REFUSED]));
      if (wrAcc && paddr == `NVAC_OFS_IRQ_MASK) begin
        irqMask_reg <= pwdata[1:0];
      end
      if (wrAcc && paddr == `NVAC_OFS_PROTECT) begin
        protect_reg <= pwdata[0];
      end
      irq <= |(irqFlags_reg & irqMask_reg);
    end
  end

  // ------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      `NVAC_OFS_ADDR_LOW: rdMux[7:0] = addrLow_reg;
      `NVAC_OFS_ADDR_HIGH: rdMux[7:0] = addrHigh_reg;
      `NVAC_OFS_DATA_LOW: rdMux[7:0] = dataLow_reg;
      `NVAC_OFS_DATA_HIGH: rdMux[7:0] = dataHigh_reg;
      `NVAC_OFS_CONTROL: rdMux[7:0] = {spaceSelect_reg, 3'b000,
        abortFlag_reg === 1'b1, storePermit_reg, storeGo_reg, readGo_reg};
      `NVAC_OFS_UNLOCK: rdMux = 32'h0000_0000;
      `NVAC_OFS_IRQ_FLAGS: rdMux[1:0] = irqFlags_reg;
      `NVAC_OFS_IRQ_MASK: rdMux[1:0] = irqMask_reg;
      `NVAC_OFS_PROTECT: rdMux[0] = protect_reg;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // zero-wait slave; only offsets above the protect register answer with pslverr
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > `NVAC_OFS_PROTECT;
      if (psel && !penable && !pwrite) begin
        prdata <= rdMux;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_permit_gate;
    @(posedge mclk) disable iff (reset)
      (startStore && !pwdata[`NVAC_BIT_PERMIT]) |=> !storeGo_reg;
  endproperty
  a_permit_gate: assert property (p_permit_gate)
    else $error("write happened without permit");
  property p_done_flag;
    @(posedge mclk) disable iff (reset)
      (opDone && state_reg == NVAC_STORE) |=> irqFlags_reg[`NVAC_BIT_DONE];
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("done flag not set after write");
  property p_go_clear;
    @(posedge mclk) disable iff (reset)
      (opDone && state_reg == NVAC_READ) |=> !readGo_reg;
  endproperty
  a_go_clear: assert property (p_go_clear)
    else $error("read go not cleared");
  // erase phase length in cycles, the timer reload plus one
  localparam int EraseLen = `NVAC_WRITE_CYCLES;
  sequence s_start;
    startStore && storeOk && !newSpace;
  endsequence
  sequence s_erase_then_store;
    state_reg == NVAC_ERASE ##EraseLen state_reg == NVAC_STORE;
  endsequence
  property p_erase_first;
    @(posedge mclk) disable iff (reset) s_start |=> s_erase_then_store;
  endproperty
  a_erase_first: assert property (p_erase_first)
    else $error("data write did not erase first");
  property p_unlock_zero;
    @(posedge mclk) disable iff (reset)
      (rdAcc && paddr == `NVAC_OFS_UNLOCK) |-> prdata == 32'h0000_0000;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero)
    else $error("unlock port read nonzero");
  property p_key_needed;
    @(posedge mclk) disable iff (reset)
      $rose(storeGo_reg) |-> $past(unlocked);
  endproperty
  a_key_needed: assert property (p_key_needed)
    else $error("write started without key");
  property p_protect;
    @(posedge mclk) disable iff (reset)
      (startStore && newSpace && protect_reg) |=> !storeGo_reg;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected program write");
  property p_no_abort_clear;
    @(posedge mclk) disable iff (reset)
      (storeGo_reg && !opDone && wrAcc && paddr == `NVAC_OFS_CONTROL)
      |=> storeGo_reg;
  endproperty
  a_no_abort_clear: assert property (p_no_abort_clear)
    else $error("write aborted by software");
endmodule

//--- testbench/testbench.sv
// self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
`include "nvac_consts.svh"
module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic watch = 1'b0;
  logic [32:0] expQ[$];
  logic [32:0] expNow;
  logic [13:0] lastD[2];
  int errTotal = 0;
  int checked = 0;
  int seed = 67513;

  always #50 mclk = ~mclk;

  nvac_top DUT (
    .mclk(mclk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq)
  );

  // ------------------------------------------------------------
  // compare and close
  // ------------------------------------------------------------
  task automatic closeOut;
    if (errTotal == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ------------------------------------------------------------
  // apb master
  // ------------------------------------------------------------
  // one idle cycle after each transfer keeps psel from being driven
  // twice in a single time step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic c,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    watch <= c;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    if (n >= 50) begin
      errTotal++;
      closeOut();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    watch <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 1'b0, r);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e,
                       input logic err = 1'b0);
    logic [31:0] r;
    expQ.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000, 1'b1, r);
  endtask

  task automatic poll(input logic [31:0] mask);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      apb(1'b0, `NVAC_OFS_CONTROL, 32'h0000_0000, 1'b0, r);
      n++;
    end while ((r & mask) !== 32'h0000_0000 && n < 200);
    if (n >= 200) begin
      errTotal++;
      closeOut();
    end
  endtask

  task automatic setup(input logic [7:0] ah, input logic [7:0] al,
                       input logic [13:0] d);
    wr(`NVAC_OFS_ADDR_LOW, {24'h000000, al});
    wr(`NVAC_OFS_ADDR_HIGH, {24'h000000, ah});
    wr(`NVAC_OFS_DATA_LOW, {24'h000000, d[7:0]});
    wr(`NVAC_OFS_DATA_HIGH, {26'h0000000, d[13:8]});
  endtask

  task automatic keys;
    wr(`NVAC_OFS_UNLOCK, {24'h000000, 8'(`NVAC_KEY_FIRST)});
    wr(`NVAC_OFS_UNLOCK, {24'h000000, 8'(`NVAC_KEY_SECOND)});
  endtask

  task automatic getChk(input logic s, input logic [7:0] ah,
                        input logic [7:0] al, input logic [13:0] d);
    wr(`NVAC_OFS_ADDR_LOW, {24'h000000, al});
    wr(`NVAC_OFS_ADDR_HIGH, {24'h000000, ah});
    // spoil the data pair so only a real read can restore it
    wr(`NVAC_OFS_DATA_LOW, {24'h000000, ~d[7:0]});
    wr(`NVAC_OFS_DATA_HIGH, {26'h0000000, ~d[13:8]});
    wr(`NVAC_OFS_CONTROL, {24'h000000, s, 7'h01});
    poll(32'h0000_0001);
    rdChk(`NVAC_OFS_DATA_LOW, {24'h000000, d[7:0]});
    if (s)
      rdChk(`NVAC_OFS_DATA_HIGH, {26'h0000000, d[13:8]});
  endtask

  // read results are compared as they appear on the bus
  always @(posedge mclk) begin
    if (watch && psel && penable && pready === 1'b1 && !pwrite) begin
      if (expQ.size() == 0) begin
        errTotal++;
        $display("wrong value read expected none seen %h", prdata);
      end else begin
        expNow = expQ.pop_front();
        check({pslverr, prdata}, expNow, "read");
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    closeOut();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin : main
    logic [7:0] ah;
    logic [7:0] al;
    logic [13:0] d;
    logic s;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdChk(`NVAC_OFS_CONTROL, 32'h0000_0000);
    rdChk(`NVAC_OFS_IRQ_FLAGS, 32'h0000_0000);
    wr(`NVAC_OFS_UNLOCK, 32'h0000_00FF);
    rdChk(`NVAC_OFS_UNLOCK, 32'h0000_0000);
    rdChk(12'h024, 32'h0000_0000, 1'b1);
    wr(`NVAC_OFS_PROTECT, 32'h0000_0000);
    wr(`NVAC_OFS_IRQ_MASK, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      s = i[1];
      al = i[0] ? 8'hFF : 8'($random(seed));
      ah = i[0] ? 8'h7F : {1'b0, 7'($random(seed))};
      d = 14'($random(seed));
      if (!s)
        d[13:8] = 6'h00;
      lastD[s] = d;
      wr(`NVAC_OFS_IRQ_FLAGS, 32'h0000_0003);
      setup(ah, al, d);
      keys();
      wr(`NVAC_OFS_CONTROL, {24'h000000, s, 7'h06});
      wr(`NVAC_OFS_CONTROL, {24'h000000, s, 7'h04});
      rdChk(`NVAC_OFS_CONTROL, {24'h000000, s, 7'h06});
      poll(32'h0000_0002);
      rdChk(`NVAC_OFS_CONTROL, {24'h000000, s, 7'h04});
      rdChk(`NVAC_OFS_IRQ_FLAGS, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      check({32'h0, irq}, 33'h1, "irq");
      wr(`NVAC_OFS_IRQ_FLAGS, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      check({32'h0, irq}, 33'h0, "irq");
      // data space must ignore the high address byte
      getChk(s, s ? ah : ah ^ 8'h5A, al, d);
    end
    // refused stores leave the stored value untouched, flag stays masked
    wr(`NVAC_OFS_IRQ_MASK, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      s = (k == 3);
      setup(8'h7F, 8'hFF, ~lastD[s]);
      case (k)
        0: wr(`NVAC_OFS_CONTROL, 32'h0000_0006);
        1: begin
          wr(`NVAC_OFS_UNLOCK, {24'h000000, 8'(`NVAC_KEY_FIRST)});
          wr(`NVAC_OFS_ADDR_LOW, 32'h0000_00FF);
          wr(`NVAC_OFS_UNLOCK, {24'h000000, 8'(`NVAC_KEY_SECOND)});
          wr(`NVAC_OFS_CONTROL, 32'h0000_0006);
        end
        2: begin
          keys();
          wr(`NVAC_OFS_CONTROL, 32'h0000_0002);
        end
        default: begin
          wr(`NVAC_OFS_PROTECT, 32'h0000_0001);
          keys();
          wr(`NVAC_OFS_CONTROL, 32'h0000_0086);
        end
      endcase
      repeat (90) @(posedge mclk);
      rdChk(`NVAC_OFS_IRQ_FLAGS, 32'h0000_0002);
      check({32'h0, irq}, 33'h0, "irq");
      wr(`NVAC_OFS_IRQ_FLAGS, 32'h0000_0003);
      getChk(s, 8'h7F, 8'hFF, lastD[s]);
    end
    // a reset in mid-write must leave the abort flag behind
    wr(`NVAC_OFS_PROTECT, 32'h0000_0000);
    setup(8'h00, 8'h11, 14'h0022);
    keys();
    wr(`NVAC_OFS_CONTROL, 32'h0000_0006);
    repeat (5) @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdChk(`NVAC_OFS_CONTROL, 32'h0000_0008);
    wr(`NVAC_OFS_CONTROL, 32'h0000_0000);
    rdChk(`NVAC_OFS_CONTROL, 32'h0000_0000);
    closeOut();
  end
endmodule
